// file: logic/fle_core.sv
// fle_core: exponent load and float load execution with register file
// assumes: operands arrive fetched on clock_i; register port is
// driven by a master on the same clock, strobes one cycle long
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps

// Overview of operation
// - exponent load copies the source exponent into the destination exponent and keeps the destination mantissa.
// - if the copied exponent is the zero exponent of the source precision the destination mantissa becomes zero.
// - an immediate source of the exponent load is read as a short float before its exponent is taken.
// - the two-bit mode picks register, direct 01, indirect 10 or immediate source; the destination is one of eight registers.
// - float load writes the whole source operand into the destination unchanged.
// - both loads handle exponent and mantissa fields as floating-point values.
// - float load updates flags only for an extended register destination, otherwise flags hold.
// - on float load underflow and overflow clear, negative and zero follow the result, latched flags and carry hold.
// - neither load depends on the saturation-on-overflow mode bit.
module fle_core (
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  input  wire logic              ce_i,
  input  wire fle_pkg::fle_op_t  op_i,
  input  wire logic [7:0]        addr_i,
  input  wire logic [31:0]       wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [31:0]       rdata_o,
  output fle_pkg::fle_flags_t    flags_o,
  output logic      [39:0]       result_o,
  output logic                   done_o
);

  // ==========================================================
  // declarations
  logic [39:0]         rf_q [fle_pkg::NREG];
  logic [39:0]         src_reg_val;
  logic [39:0]         dst_old;
  logic [39:0]         src_ext;
  logic                src_zero;
  logic [39:0]         res;
  logic                exec;
  logic                is_ldf;

  logic                reg_area;
  logic [2:0]          bus_idx;
  logic                bus_hi;
  logic                wr_reg;

  fle_pkg::fle_flags_t flags_r;
  fle_pkg::fle_flags_t flags_nxt;
  logic [1:0]          ctrl_r;
  logic [1:0]          ctrl_nxt;
  logic [15:0]         count_r;
  logic [15:0]         count_nxt;
  logic [31:0]         rdata_r;
  logic [31:0]         rdata_nxt;
  logic [39:0]         result_r;
  logic [39:0]         result_nxt;
  logic                done_r;
  logic                done_nxt;

  // ==========================================================
  // operand fetch
  always_comb begin
    src_reg_val = rf_q[op_i.src_reg];
    dst_old     = rf_q[op_i.dst];
  end

  fle_src_fmt u_src (
    .mode_i (op_i.mode),
    .reg_i  (src_reg_val),
    .mem_i  (op_i.mem),
    .imm_i  (op_i.imm),
    .ext_o  (src_ext),
    .zero_o (src_zero)
  );

  // ==========================================================
  // execute: one cycle per load, saturation bit never consulted
  always_comb begin
    exec   = op_i.valid & ctrl_r[fle_pkg::CTRL_EN_BIT];
    is_ldf = (op_i.kind == fle_pkg::OP_FLOAT_LOAD);
    if (is_ldf) begin
      res = src_ext;
    end else if (src_zero) begin
      res = {src_ext[39:32], 32'h00000000};
    end else begin
      res = {src_ext[39:32], dst_old[31:0]};
    end
  end

  // ==========================================================
  // register port decode
  always_comb begin
    reg_area = (addr_i < fle_pkg::OFF_FLAGS) && (addr_i[1:0] == 2'h0);
    bus_idx  = addr_i[5:3];
    bus_hi   = addr_i[fle_pkg::REG_HI_BIT];
    wr_reg   = wr_i & reg_area;
  end

  // ==========================================================
  // register file: one entry per generate step
  genvar g;
  generate
    for (g = 0; g < fle_pkg::NREG; g = g + 1) begin : g_rf
      logic [39:0] ent_r;
      logic [39:0] ent_nxt;

      always_comb begin
        ent_nxt = ent_r;
        if (wr_reg && (bus_idx == 3'(g))) begin
          if (bus_hi) begin
            ent_nxt[39:32] = wdata_i[7:0];
          end else begin
            ent_nxt[31:0] = wdata_i;
          end
        end
        // a load landing in the same cycle wins over software
        if (exec && (op_i.dst == 3'(g))) begin
          ent_nxt = res;
        end
      end

      always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
          ent_r <= fle_pkg::REG_RST;
        end else if (ce_i) begin
          ent_r <= ent_nxt;
        end
      end

      assign rf_q[g] = ent_r;
    end
  endgenerate

  // ==========================================================
  // condition flags
  always_comb begin
    flags_nxt = flags_r;
    if (wr_i && (addr_i == fle_pkg::OFF_FLAGS)) begin
      flags_nxt = wdata_i[6:0];
    end
    // every destination index names an extended register
    if (exec && is_ldf) begin
      flags_nxt.underflow_flag = 1'b0;
      flags_nxt.ovf            = 1'b0;
      flags_nxt.zero = (res[39:32] == fle_pkg::EXP_ZERO);
      flags_nxt.neg  = res[31] &&
                       (res[39:32] != fle_pkg::EXP_ZERO);
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      flags_r <= fle_pkg::FLAGS_RST;
    end else if (ce_i) begin
      flags_r <= flags_nxt;
    end
  end

  // ==========================================================
  // control and activity counter
  always_comb begin
    ctrl_nxt  = ctrl_r;
    count_nxt = count_r;
    if (wr_i && (addr_i == fle_pkg::OFF_CTRL)) begin
      ctrl_nxt = wdata_i[1:0];
    end
    if (wr_i && (addr_i == fle_pkg::OFF_COUNT)) begin
      count_nxt = wdata_i[15:0];
    end
    if (exec) begin
      count_nxt = count_r + 16'h0001;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ctrl_r  <= fle_pkg::CTRL_RST;
      count_r <= fle_pkg::COUNT_RST;
    end else if (ce_i) begin
      ctrl_r  <= ctrl_nxt;
      count_r <= count_nxt;
    end
  end

  // ==========================================================
  // result and completion
  always_comb begin
    done_nxt   = exec;
    result_nxt = result_r;
    if (exec) begin
      result_nxt = res;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      done_r   <= 1'b0;
      result_r <= fle_pkg::REG_RST;
    end else if (ce_i) begin
      done_r   <= done_nxt;
      result_r <= result_nxt;
    end
  end

  // ==========================================================
  // read port: data stands in the cycle after the strobe only
  always_comb begin
    rdata_nxt = 32'h00000000;
    if (rd_i) begin
      if (reg_area) begin
        if (bus_hi) begin
          rdata_nxt = {24'h000000, rf_q[bus_idx][39:32]};
        end else begin
          rdata_nxt = rf_q[bus_idx][31:0];
        end
      end else begin
        case (addr_i)
          fle_pkg::OFF_FLAGS: rdata_nxt = {25'h0000000, flags_r};
          fle_pkg::OFF_CTRL:  rdata_nxt = {30'h00000000, ctrl_r};
          fle_pkg::OFF_COUNT: rdata_nxt = {16'h0000, count_r};
          default:            rdata_nxt = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rdata_r <= 32'h00000000;
    end else if (ce_i) begin
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign rdata_o  = rdata_r;
  assign flags_o  = flags_r;
  assign result_o = result_r;
  assign done_o   = done_r;

endmodule : fle_core

// file: logic/fle_pkg.sv
// fle_pkg: constants and carrier types for the float load datapath
// assumes: one clock domain, sources already fetched by address logic
package fle_pkg;

  // ==========================================================
  // operand formats
  localparam int EXT_W     = 40;
  localparam int MAN_W     = 32;
  localparam int EXP_W     = 8;
  localparam int MEM_W     = 32;
  localparam int IMM_W     = 16;
  localparam int NREG      = 8;
  localparam int REG_IDX_W = 3;
  localparam int SIMM_FR_W = 11;
  localparam int SIMM_PAD  = 20;
  localparam int MEM_PAD   = 8;

  // reserved exponent that marks a zero value
  localparam logic [7:0] EXP_ZERO       = 8'h80;
  localparam logic [3:0] SHORT_EXP_ZERO = 4'h8;

  // ==========================================================
  // source addressing modes and operations
  localparam logic [1:0] MODE_REG = 2'h0;
  localparam logic [1:0] MODE_DIR = 2'h1;
  localparam logic [1:0] MODE_IND = 2'h2;
  localparam logic [1:0] MODE_IMM = 2'h3;

  localparam logic OP_EXP_LOAD   = 1'h0;
  localparam logic OP_FLOAT_LOAD = 1'h1;

  // ==========================================================
  // register port map (byte addresses)
  localparam int         ADDR_W     = 8;
  localparam int         DATA_W     = 32;
  localparam logic [7:0] OFF_REG    = 8'h00;
  localparam logic [7:0] OFF_FLAGS  = 8'h40;
  localparam logic [7:0] OFF_CTRL   = 8'h44;
  localparam logic [7:0] OFF_COUNT  = 8'h48;
  localparam int         REG_HI_BIT = 2;
  localparam int         CNT_W      = 16;

  // control register fields
  localparam int         CTRL_EN_BIT  = 0;
  localparam int         CTRL_SAT_BIT = 1;
  localparam int         CTRL_W       = 2;

  // values after reset
  localparam logic [39:0] REG_RST   = 40'h80_0000_0000;
  localparam logic [6:0]  FLAGS_RST = 7'h00;
  localparam logic [1:0]  CTRL_RST  = 2'h1;
  localparam logic [15:0] COUNT_RST = 16'h0000;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic                 valid;
    logic                 kind;
    logic [1:0]           mode;
    logic [REG_IDX_W-1:0] dst;
    logic [REG_IDX_W-1:0] src_reg;
    logic [MEM_W-1:0]     mem;
    logic [IMM_W-1:0]     imm;
  } fle_op_t;

  typedef struct packed {
    logic latched_underflow_flag;
    logic latched_overflow_flag;
    logic underflow_flag;
    logic neg;
    logic zero;
    logic ovf;
    logic carry;
  } fle_flags_t;

endpackage : fle_pkg

// file: logic/fle_src_fmt.sv
// fle_src_fmt: widens the selected source operand to extended format
// assumes: memory words are single precision, immediates short float
`timescale 1ns/1ps

module fle_src_fmt (
  input  wire logic [1:0]  mode_i,
  input  wire logic [39:0] reg_i,
  input  wire logic [31:0] mem_i,
  input  wire logic [15:0] imm_i,
  output logic      [39:0] ext_o,
  output logic             zero_o
);

  logic [3:0] s_exp;
  logic [7:0] s_exp_ext;

  // ==========================================================
  // short float immediate: 4-bit exponent, sign, 11-bit fraction
  always_comb begin
    s_exp = imm_i[15:12];
    if (s_exp == fle_pkg::SHORT_EXP_ZERO) begin
      s_exp_ext = fle_pkg::EXP_ZERO;
    end else begin
      s_exp_ext = {{4{s_exp[3]}}, s_exp};
    end
  end

  // ==========================================================
  // source select
  always_comb begin
    case (mode_i)
      fle_pkg::MODE_REG: ext_o = reg_i;
      fle_pkg::MODE_DIR,
      fle_pkg::MODE_IND: ext_o = {mem_i, 8'h00};
      fle_pkg::MODE_IMM: ext_o = {s_exp_ext, imm_i[11:0], 20'h00000};
      default:           ext_o = reg_i;
    endcase
    // each precision's zero exponent lands on the extended one
    zero_o = (ext_o[39:32] == fle_pkg::EXP_ZERO);
  end

endmodule : fle_src_fmt

// file: test/fle_core_sva.sv
// fle_core_sva: timing and field checks on the load core ports
// assumes: bound into fle_core, one clock, synchronous reset
`timescale 1ns/1ps

module fle_core_sva (
  input wire logic                clock_i,
  input wire logic                rst_n_i,
  input wire logic                ce_i,
  input wire fle_pkg::fle_op_t    op_i,
  input wire logic                wr_i,
  input wire fle_pkg::fle_flags_t flags_o,
  input wire logic [39:0]         result_o,
  input wire logic                done_o
);
  // ==========================================================
  // op and strobe seen at the previous edge
  fle_pkg::fle_op_t op_q;
  logic             ce_q;
  logic             wr_q;
  always_ff @(posedge clock_i) begin
    op_q <= op_i;
    ce_q <= ce_i;
    wr_q <= wr_i;
  end

  // ==========================================================
  // checks
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  chk_done_cause: assert property (
    done_o && ce_q |-> op_q.valid) else $error("done without op");
  chk_ldf_mem: assert property (
    done_o && op_q.kind && (op_q.mode[1] ^ op_q.mode[0])
    |-> result_o == {op_q.mem, 8'h00}) else $error("load word wrong");
  chk_ldf_flags: assert property (
    done_o && op_q.kind |-> !flags_o.underflow_flag && !flags_o.ovf
    && flags_o.zero == (result_o[39:32] == 8'h80)
    && flags_o.neg == (result_o[31] && !flags_o.zero))
    else $error("load flags wrong");
  chk_ldf_keep: assert property (
    done_o && op_q.kind && !wr_q |-> {flags_o[6:5], flags_o[0]}
    == $past({flags_o[6:5], flags_o[0]})) else $error("kept flag moved");
  chk_lde_flags: assert property (
    done_o && !op_q.kind && !wr_q |-> $stable(flags_o))
    else $error("exponent load moved flags");
  chk_lde_zero: assert property (
    done_o && !op_q.kind && result_o[39:32] == 8'h80
    |-> result_o[31:0] == 32'h0) else $error("zero mantissa kept");
  chk_lde_imm: assert property (
    done_o && !op_q.kind && op_q.mode == fle_pkg::MODE_IMM
    |-> result_o[39:32] == (op_q.imm[15:12] == 4'h8 ? 8'h80
    : {{4{op_q.imm[15]}}, op_q.imm[15:12]})) else $error("short exp");
  chk_lde_mem: assert property (
    done_o && !op_q.kind && (op_q.mode[1] ^ op_q.mode[0])
    |-> result_o[39:32] == op_q.mem[31:24]) else $error("exp wrong");

  cover property (done_o && op_q.kind);
  cover property (done_o && !op_q.kind && result_o[39:32] == 8'h80);
  cover property (done_o && !op_q.kind && op_q.mode == 2'h3);
endmodule : fle_core_sva

bind fle_core fle_core_sva i_fle_core_sva (.clock_i, .rst_n_i, .ce_i,
  .op_i, .wr_i, .flags_o, .result_o, .done_o);

// file: test/test_float_load_exec.sv
// test_float_load_exec: row table of loads, then flag and reset cases
// assumes: fle_core register map and one-cycle op latency
`timescale 1ns/1ps

module test_float_load_exec;
  typedef struct packed {
    logic        kind;
    logic [1:0]  mode;
    logic [2:0]  dst;
    logic [2:0]  src;
    logic [31:0] mem;
    logic [15:0] imm;
    logic [39:0] res;
    logic [6:0]  flg;
  } fle_row_t;
  logic                clock_i;
  logic                rst_n_i;
  logic                ce_i;
  fle_pkg::fle_op_t    op_i;
  logic [7:0]          addr_i;
  logic [31:0]         wdata_i;
  logic                wr_i;
  logic                rd_i;
  logic [31:0]         rdata_o;
  fle_pkg::fle_flags_t flags_o;
  logic [39:0]         result_o;
  logic                done_o;
  logic [31:0]         d;
  fle_row_t            rows [8];
  int                  n_errors = 0;
  int                  tests_run = 0;

  fle_core i_fle_core (.clock_i, .rst_n_i, .ce_i, .op_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .flags_o, .result_o, .done_o);

  // ==========================================================
  // compare, bus and op tasks
  task automatic diff(input logic [39:0] g, input logic [39:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask : diff
  task automatic cmp_res(input logic [39:0] g, input logic [39:0] e);
    diff(g, e);
  endtask : cmp_res
  task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e);
    diff({8'h0, g}, {8'h0, e});
  endtask : cmp_rd
  task automatic cmp_flg(input logic [6:0] g, input logic [6:0] e);
    diff({33'h0, g}, {33'h0, e});
  endtask : cmp_flg
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'h1;
    @(posedge clock_i);
    wr_i <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'h1;
    @(posedge clock_i);
    rd_i <= 1'h0;
    #1;
    v = rdata_o;
  endtask : rd
  task automatic ex(input fle_row_t r, input logic dn);
    @(posedge clock_i);
    op_i <= '{1'h1, r.kind, r.mode, r.dst, r.src, r.mem, r.imm};
    @(posedge clock_i);
    op_i.valid <= 1'h0;
    #1;
    cmp_rd({31'h0, done_o}, {31'h0, dn});
    cmp_res(result_o, r.res);
    cmp_flg(flags_o, r.flg);
  endtask : ex
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  // ==========================================================
  // clock, watchdog, sequence
  initial begin
    clock_i = 1'h0;
    forever #4 clock_i = ~clock_i;
  end
  initial begin
    #200000;
    n_errors++;
    summarize();
  end
  initial begin
    rst_n_i = 1'h0;
    ce_i = 1'h1;
    op_i = '0;
    addr_i = 8'h0;
    wdata_i = 32'h0;
    wr_i = 1'h0;
    rd_i = 1'h0;
    // bit 31 of the widened word is the sign, so c5.. and 84.. are negative
    rows = '{
      '{1'h1, 2'h1, 3'h2, 3'h0, 32'h10c52a00, 16'h0, 40'h10c52a0000,
        7'h08},
      '{1'h1, 2'h2, 3'h7, 3'h0, 32'h0584c000, 16'h0, 40'h0584c00000,
        7'h08},
      '{1'h1, 2'h3, 3'h1, 3'h0, 32'h0, 16'h8000, 40'h8000000000, 7'h04},
      '{1'h1, 2'h0, 3'h3, 3'h2, 32'h0, 16'h0, 40'h10c52a0000, 7'h08},
      '{1'h0, 2'h0, 3'h5, 3'h0, 32'h0, 16'h0, 40'h02056fe332, 7'h08},
      '{1'h0, 2'h3, 3'h5, 3'h0, 32'h0, 16'h3abc, 40'h03056fe332, 7'h08},
      '{1'h0, 2'h3, 3'h5, 3'h0, 32'h0, 16'hf123, 40'hff056fe332, 7'h08},
      '{1'h0, 2'h1, 3'h5, 3'h0, 32'h80123456, 16'h0, 40'h8000000000,
        7'h08}};
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'h1;
    wr(8'h00, 32'h00056f30);
    wr(8'h04, 32'h02);
    wr(8'h28, 32'h056fe332);
    wr(8'h2c, 32'h0a);
    foreach (rows[i]) ex(rows[i], 1'h1);
    rd(8'h28, d);
    cmp_rd(d, 32'h0);
    $display("row table done");
    wr(8'h40, 32'h7f);
    ex('{1'h0, 2'h0, 3'h4, 3'h3, 32'h0, 16'h0, 40'h1000000000, 7'h7f}, 1'h1);
    ex('{1'h1, 2'h1, 3'h4, 3'h0, 32'h10c52a00, 16'h0, 40'h10c52a0000,
      7'h69}, 1'h1);
    wr(8'h44, 32'h3);
    ex('{1'h1, 2'h1, 3'h6, 3'h0, 32'h0584c000, 16'h0, 40'h0584c00000, 7'h69}, 1'h1);
    wr(8'h44, 32'h0);
    ex('{1'h1, 2'h1, 3'h6, 3'h0, 32'h12345678, 16'h0, 40'h0584c00000, 7'h69}, 1'h0);
    rd(8'h80, d);
    cmp_rd(d, 32'h0);
    $display("flag and mode cases done");
    @(posedge clock_i);
    rst_n_i <= 1'h0;
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'h1;
    rd(8'h34, d);
    cmp_rd(d, 32'h80);
    rd(8'h40, d);
    cmp_rd(d, 32'h0);
    cmp_res(result_o, 40'h8000000000);
    $display("reset case done");
    // clock enable low: the op must leave no trace
    @(posedge clock_i);
    ce_i <= 1'h0;
    ex('{1'h1, 2'h1, 3'h6, 3'h0, 32'h12345678, 16'h0, 40'h8000000000,
      7'h00}, 1'h0);
    ce_i <= 1'h1;
    $display("clock enable case done");
    summarize();
  end
endmodule : test_float_load_exec
